// ### epo_pulse_gen.sv
`timescale 1ns/1ps
// Behaviour
// R1 - Calibration rate is 160, 16 or 8 times low rate per select pins.
// R2 - Calibration pulses come from the same filtered power, short accumulation.
// R3 - Low-rate outputs alternate active high pulses of 275 ms.
// R4 - Second low-rate rising edge about half a period after the first.
// R5 - Low-rate period under 550 ms gives pulse width of half the period.
// R6 - Calibration pulse is 96 ms active high, rate proportional to power.
// R7 - Calibration period under 192 ms gives pulse width of half the period.
// R8 - Scale high, both frequency selects low: calibration width 66 % of period.
// R9 - No pulses on any output while load is below the minimum rate.
// R10 - Minimum rate is 0.005 % of full scale for every setting.
// R11 - Negative power flag high when any phase shows negative power.
// R12 - Flag stays high until all phases measure positive power.
// R13 - Flag changes only when a calibration pulse is issued.
// R14 - Phases under no load are ignored for the flag until load returns.
// R15 - Base frequency picked from the three select pins per the table.
// R16 - Low-rate frequency proportional to summed phase power times base frequency.
// R17 - Energy accumulator crossings give calibration pulses, multiples give low-rate.
// R18 - All widths and period comparisons counted in master clock cycles.
module epo_pulse_gen #(
  parameter int                         LR_WIDTH_CYC      = epo_pkg::LR_WIDTH_CYC,
  parameter int                         LR_SHORT_CYC      = epo_pkg::LR_SHORT_CYC,
  parameter int                         CAL_WIDTH_CYC     = epo_pkg::CAL_WIDTH_CYC,
  parameter int                         CAL_SHORT_CYC     = epo_pkg::CAL_SHORT_CYC,
  parameter logic [epo_pkg::ACC_W-1:0]  CAL_ENERGY_THRESH = epo_pkg::CAL_ENERGY_THRESH_DEF
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst,
  input  wire logic                                cal_scale_select,
  input  wire logic                                freq_select_hi,
  input  wire logic                                freq_select_lo,
  input  wire logic                                sample_strobe,
  input  wire logic signed [epo_pkg::PHASE_W-1:0]  phase_power_a,
  input  wire logic signed [epo_pkg::PHASE_W-1:0]  phase_power_b,
  input  wire logic signed [epo_pkg::PHASE_W-1:0]  phase_power_c,
  output logic                                     low_rate_pulse_a,
  output logic                                     low_rate_pulse_b,
  output logic                                     cal_pulse_out,
  output logic                                     negative_power_flag
);
  localparam int PW = epo_pkg::PHASE_W;
  localparam int AW = epo_pkg::ACC_W;
  localparam int MW = epo_pkg::MULT_W;

  logic [2:0]           sel;
  logic signed [PW-1:0] phase_power [3];
  logic [2:0]           phase_neg;
  logic signed [PW+1:0] total;
  logic [PW+1:0]        total_mag;
  logic                 no_load;
  logic [MW-1:0]        mult;
  logic [AW-1:0]        increment;
  logic [AW:0]          acc_sum;
  logic [AW-1:0]        energy_acc;
  logic [MW-1:0]        cal_count;
  logic                 cal_event;
  logic                 lr_event;
  logic                 lr_dest;
  logic                 lr_pulse;
  logic [AW-1:0]        next_energy_acc;
  logic [MW-1:0]        next_cal_count;
  logic                 next_cal_event;
  logic                 next_lr_event;
  logic                 next_lr_dest;
  logic                 next_negative_power_flag;

  assign sel            = {cal_scale_select, freq_select_hi, freq_select_lo};
  assign phase_power[0] = phase_power_a;
  assign phase_power[1] = phase_power_b;
  assign phase_power[2] = phase_power_c;
  assign mult           = epo_pkg::cal_multiple(sel);  // see R1

  // Per-phase sign check; a phase inside the no-load band never counts
  for (genvar i = 0; i < 3; i++) begin : g_phase
    logic [PW:0] mag;
    assign mag          = phase_power[i][PW-1] ? (PW+1)'(-(PW+1)'(phase_power[i]))
                                               : (PW+1)'(phase_power[i]);
    assign phase_neg[i] = phase_power[i][PW-1] &&
                          mag >= (PW+1)'(epo_pkg::NOLOAD_PHASE);  // see R11, see R14
  end

  // Summed power, magnitude scaled by base frequency and calibration multiple
  always_comb begin
    total     = (PW+2)'(phase_power[0]) + (PW+2)'(phase_power[1]) + (PW+2)'(phase_power[2]);
    total_mag = total[PW+1] ? (PW+2)'(-total) : (PW+2)'(total);
    no_load   = total_mag < (PW+2)'(epo_pkg::NOLOAD_TOTAL);  // see R10
    increment = AW'(total_mag) * AW'(epo_pkg::base_weight(sel)) * AW'(mult);  // see R15, see R16
    acc_sum   = (AW+1)'(energy_acc) + (AW+1)'(increment);
  end

  // Accumulator and pulse events; one crossing per sample at most
  always_comb begin
    next_energy_acc          = energy_acc;
    next_cal_event           = 1'b0;
    next_cal_count           = cal_count;
    next_lr_event            = 1'b0;
    next_lr_dest             = lr_dest;
    next_negative_power_flag = negative_power_flag;
    if (sample_strobe && !no_load) begin  // see R9
      if (acc_sum >= (AW+1)'(CAL_ENERGY_THRESH)) begin
        next_energy_acc = AW'(acc_sum - (AW+1)'(CAL_ENERGY_THRESH));  // see R2, see R17
        next_cal_event  = 1'b1;
      end else begin
        next_energy_acc = AW'(acc_sum);
      end
    end
    if (cal_event) begin
      next_negative_power_flag = |phase_neg;  // see R11, see R12, see R13
      // A select change mid-count wraps at once rather than overrunning
      if (cal_count >= mult - MW'(1)) begin
        next_cal_count = epo_pkg::COUNT_RST;
        next_lr_event  = 1'b1;  // see R1, see R17
      end else begin
        next_cal_count = cal_count + MW'(1);
      end
    end
    if (lr_event) begin
      next_lr_dest = ~lr_dest;  // see R3, see R4
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      energy_acc          <= epo_pkg::ACC_RST;
      cal_count           <= epo_pkg::COUNT_RST;
      cal_event           <= 1'b0;
      lr_event            <= 1'b0;
      lr_dest             <= 1'b0;
      negative_power_flag <= 1'b0;
    end else begin
      energy_acc          <= next_energy_acc;
      cal_count           <= next_cal_count;
      cal_event           <= next_cal_event;
      lr_event            <= next_lr_event;
      lr_dest             <= next_lr_dest;
      negative_power_flag <= next_negative_power_flag;
    end
  end

  // Calibration output shaper
  epo_pulse_shaper #(
    .WIDTH_CYC     (CAL_WIDTH_CYC),
    .SHORT_CYC     (CAL_SHORT_CYC),
    .DOUBLE_PERIOD (1'b0)
  ) u_cal_shaper (
    .core_clk   (core_clk),
    .rst        (rst),
    .fire       (cal_event),
    .two_thirds (epo_pkg::two_thirds_mode(sel)),
    .pulse      (cal_pulse_out)
  );

  // One shaper for both low-rate pins; each pin sees every second event,
  // so its own period is twice the event spacing
  epo_pulse_shaper #(
    .WIDTH_CYC     (LR_WIDTH_CYC),
    .SHORT_CYC     (LR_SHORT_CYC),
    .DOUBLE_PERIOD (1'b1)
  ) u_lr_shaper (
    .core_clk   (core_clk),
    .rst        (rst),
    .fire       (lr_event),
    .two_thirds (1'b0),
    .pulse      (lr_pulse)
  );

  // Steering to the pin chosen at the event; both inputs are flops
  assign low_rate_pulse_a = lr_pulse & lr_dest;  // see R3
  assign low_rate_pulse_b = lr_pulse & ~lr_dest;  // see R4

  cal_noload_a: assert property (@(posedge core_clk) disable iff (rst)  // see R9
    (!sample_strobe || no_load) |=> !cal_event)
    else $error("calibration event without loaded sample");

  lr_every_a: assert property (@(posedge core_clk) disable iff (rst)  // see R1
    cal_event && cal_count >= mult - MW'(1) |=> lr_event && cal_count == '0)
    else $error("low-rate event missing after multiple");

  lr_only_a: assert property (@(posedge core_clk) disable iff (rst)  // see R17
    !cal_event |=> !lr_event)
    else $error("low-rate event without calibration event");

  flag_set_a: assert property (@(posedge core_clk) disable iff (rst)  // see R11
    cal_event && phase_neg != 3'b000 |=> negative_power_flag)
    else $error("negative flag not raised");

  flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)  // see R12
    cal_event && phase_neg == 3'b000 |=> !negative_power_flag)
    else $error("negative flag not cleared");

  flag_stable_a: assert property (@(posedge core_clk) disable iff (rst)  // see R13
    !cal_event |=> $stable(negative_power_flag))
    else $error("negative flag moved between calibration pulses");

  lr_alt_a: assert property (@(posedge core_clk) disable iff (rst)  // see R3
    !(low_rate_pulse_a && low_rate_pulse_b))
    else $error("low-rate pins high together");

  lr_swap_a: assert property (@(posedge core_clk) disable iff (rst)  // see R4
    lr_event |=> lr_dest != $past(lr_dest) && lr_pulse)
    else $error("low-rate event did not switch pin");

  noload_hold_a: assert property (@(posedge core_clk) disable iff (rst)  // see R9
    sample_strobe && no_load |=> $stable(energy_acc))
    else $error("accumulator moved on a no-load sample");

  cal_fire_a: assert property (@(posedge core_clk) disable iff (rst)  // see R6
    cal_event |=> cal_pulse_out)
    else $error("calibration event gave no pulse");

  lr_dest_hold_a: assert property (@(posedge core_clk) disable iff (rst)  // see R4
    !lr_event |=> $stable(lr_dest))
    else $error("low-rate pin choice moved without an event");

  cross_fire_a: assert property (@(posedge core_clk) disable iff (rst)  // see R17
    sample_strobe && !no_load && acc_sum >= (AW+1)'(CAL_ENERGY_THRESH) |=> cal_event)
    else $error("threshold crossing gave no calibration event");

  flag_pos_a: assert property (@(posedge core_clk) disable iff (rst)  // see R12
    cal_event && !phase_power_a[PW-1] && !phase_power_b[PW-1] && !phase_power_c[PW-1]
      |=> !negative_power_flag)
    else $error("negative flag high with all phases positive");

endmodule : epo_pulse_gen

// ### epo_pkg.sv
package epo_pkg;

  // Master clock
  localparam int CLK_HZ          = 100_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;

  // Pulse timing, as printed and as cycle counts
  localparam int LR_WIDTH_MS     = 275;
  localparam int LR_SHORT_MS     = 550;
  localparam int CAL_WIDTH_MS    = 96;
  localparam int CAL_SHORT_MS    = 192;
  localparam int LR_WIDTH_CYC    = LR_WIDTH_MS * CYC_PER_MS;
  localparam int LR_SHORT_CYC    = LR_SHORT_MS * CYC_PER_MS;
  localparam int CAL_WIDTH_CYC   = CAL_WIDTH_MS * CYC_PER_MS;
  localparam int CAL_SHORT_CYC   = CAL_SHORT_MS * CYC_PER_MS;

  // Shaper counter width, holds twice the longest short-period bound
  localparam int SHAPER_CW       = 27;

  // Datapath widths
  localparam int PHASE_W         = 16;
  localparam int ACC_W           = 48;
  localparam int WEIGHT_W        = 13;
  localparam int MULT_W          = 8;

  // No-load level: 0.005 % of full scale, in parts per million
  localparam int FULL_PHASE      = 32767;
  localparam int NOLOAD_PPM      = 50;
  localparam int NOLOAD_PHASE    = (FULL_PHASE * NOLOAD_PPM + 999_999) / 1_000_000;
  localparam int NOLOAD_TOTAL    = (3 * FULL_PHASE * NOLOAD_PPM + 999_999) / 1_000_000;

  // Energy per calibration pulse, default only
  localparam logic [ACC_W-1:0] CAL_ENERGY_THRESH_DEF = 48'h0000_4000_0000;

  // Reset values
  localparam logic [ACC_W-1:0]  ACC_RST   = 48'h0;
  localparam logic [MULT_W-1:0] COUNT_RST = 8'h00;

  // Base frequency in hundredths of a hertz, select order {scale, hi, lo}
  function automatic logic [WEIGHT_W-1:0] base_weight(input logic [2:0] sel);
    unique case (sel)
      3'b000:  base_weight = 13'h007f;  // 1.27
      3'b100:  base_weight = 13'h0077;  // 1.19
      3'b001:  base_weight = 13'h01fd;  // 5.09
      3'b101:  base_weight = 13'h01dd;  // 4.77
      3'b010:  base_weight = 13'h0773;  // 19.07
      3'b110:  base_weight = 13'h0773;  // 19.07
      3'b011:  base_weight = 13'h1dcd;  // 76.29
      3'b111:  base_weight = 13'h003c;  // 0.60
    endcase
  endfunction : base_weight

  // Calibration pulses per low-rate pulse
  function automatic logic [MULT_W-1:0] cal_multiple(input logic [2:0] sel);
    unique case (sel)
      3'b000, 3'b001:         cal_multiple = 8'ha0;
      3'b101, 3'b010, 3'b111: cal_multiple = 8'h10;
      3'b100, 3'b110, 3'b011: cal_multiple = 8'h08;
    endcase
  endfunction : cal_multiple

  // Setting with the two-thirds calibration pulse
  function automatic logic two_thirds_mode(input logic [2:0] sel);
    two_thirds_mode = (sel == 3'b100);
  endfunction : two_thirds_mode

endpackage : epo_pkg

// ### epo_pulse_shaper.sv
`timescale 1ns/1ps
module epo_pulse_shaper #(
  parameter int WIDTH_CYC     = epo_pkg::CAL_WIDTH_CYC,
  parameter int SHORT_CYC     = epo_pkg::CAL_SHORT_CYC,
  parameter bit DOUBLE_PERIOD = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic fire,
  input  wire logic two_thirds,
  output logic      pulse
);
  localparam int CW = epo_pkg::SHAPER_CW;

  logic [CW-1:0] interval;
  logic [CW-1:0] remaining;
  logic [CW-1:0] active_width;
  logic [CW-1:0] next_interval;
  logic [CW-1:0] next_remaining;
  logic [CW-1:0] next_active_width;
  logic          next_pulse;
  logic [CW:0]   period;
  logic          short_period;
  logic [CW:0]   width_now;

  // Width from the last measured period; the first fire sees a saturated, long period
  always_comb begin
    period       = DOUBLE_PERIOD ? {interval, 1'b0} : {1'b0, interval};
    short_period = period < (CW+1)'(SHORT_CYC);  // see R5, see R7
    if (!short_period) begin
      width_now = (CW+1)'(WIDTH_CYC);  // see R3, see R6
    end else if (two_thirds) begin
      width_now = (CW+1)'({period, 1'b0} / (CW+2)'(3));  // see R8
    end else begin
      width_now = period >> 1;  // see R5, see R7
    end
    if (width_now == '0) begin
      width_now = (CW+1)'(1);
    end
  end

  // Period measured and pulse timed in master clock cycles
  always_comb begin
    next_interval     = (interval == '1) ? interval : interval + CW'(1);  // see R18
    next_remaining    = remaining;
    next_active_width = active_width;
    next_pulse        = pulse;
    if (fire) begin
      next_interval     = CW'(1);
      next_pulse        = 1'b1;
      next_remaining    = width_now[CW-1:0] - CW'(1);
      next_active_width = width_now[CW-1:0];
    end else if (remaining != '0) begin
      next_remaining = remaining - CW'(1);
    end else begin
      next_pulse = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interval     <= '1;
      remaining    <= '0;
      active_width <= '0;
      pulse        <= 1'b0;
    end else begin
      interval     <= next_interval;
      remaining    <= next_remaining;
      active_width <= next_active_width;
      pulse        <= next_pulse;
    end
  end

  width_long_a: assert property (@(posedge core_clk) disable iff (rst)  // see R3, see R6
    fire && !short_period |=> pulse && active_width == CW'(WIDTH_CYC))
    else $error("long period pulse width wrong");

  width_half_a: assert property (@(posedge core_clk) disable iff (rst)  // see R5, see R7
    fire && short_period && !two_thirds && period >= 2 |=>
      {1'b0, active_width} == ($past(period) >> 1))
    else $error("short period pulse not half period");

  width_third_a: assert property (@(posedge core_clk) disable iff (rst)  // see R8
    fire && short_period && two_thirds && period >= 3 |=>
      (CW+3)'(active_width) * 3 <= (CW+3)'($past(period)) * 2 &&
      (CW+3)'(active_width) * 3 + 3 > (CW+3)'($past(period)) * 2)
    else $error("two-thirds pulse width wrong");

  pulse_hold_a: assert property (@(posedge core_clk) disable iff (rst)  // see R18
    pulse && remaining != '0 && !fire |=> pulse)
    else $error("pulse ended early");

  pulse_end_a: assert property (@(posedge core_clk) disable iff (rst)  // see R18
    pulse && remaining == '0 && !fire |=> !pulse)
    else $error("pulse ran long");

endmodule : epo_pulse_shaper

// ### epo_pulse_counter.sv
`timescale 1ns/1ps
// Far-side impulse counter: counts rising edges, times the last high phase
module epo_pulse_counter (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pulse,
  output int        rises,
  output int        last_width,
  output longint    last_rise
);
  int     run;
  longint cyc;
  logic   prev;

  // Width in master clock cycles, so it scales like the design's own timing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rises      <= 0;
      last_width <= 0;
      last_rise  <= 0;
      run        <= 0;
      cyc        <= 0;
      prev       <= 1'b0;
    end else begin
      cyc  <= cyc + 1;
      prev <= pulse;
      run  <= pulse ? run + 1 : 0;
      if (pulse && !prev) begin
        rises     <= rises + 1;
        last_rise <= cyc;
      end
      // Only a completed pulse reports a width
      if (!pulse && prev) begin
        last_width <= run;
      end
    end
  end
endmodule : epo_pulse_counter

// ### tb_energy_pulse_output_gen.sv
`timescale 1ns/1ps
module tb_energy_pulse_output_gen;
  localparam int LRW = 20;
  localparam int CALW = 8;
  logic                                core_clk = 1'b0;
  logic                                rst = 1'b1;
  logic [2:0]                          sel = 3'h0;
  logic                                sample_strobe = 1'b0;
  logic signed [epo_pkg::PHASE_W-1:0]  ph_a = 16'h0000;
  logic signed [epo_pkg::PHASE_W-1:0]  ph_b = 16'h0000;
  logic signed [epo_pkg::PHASE_W-1:0]  ph_c = 16'h0000;
  logic                                lr_a, lr_b, cal, flag;
  int                                  a_rises, b_rises, cal_rises;
  int                                  a_width, b_width, cal_width;
  longint                              a_rise, b_rise, cal_rise;
  int                                  mismatches = 0;
  int                                  checked = 0;
  int                                  mults [8] = '{160, 160, 16, 8, 8, 16, 8, 16};

  // Shortened widths keep the run brief; SHORT stays twice WIDTH
  epo_pulse_gen #(
    .LR_WIDTH_CYC      (LRW),
    .LR_SHORT_CYC      (2 * LRW),
    .CAL_WIDTH_CYC     (CALW),
    .CAL_SHORT_CYC     (2 * CALW),
    .CAL_ENERGY_THRESH (48'h0000000186a0)
  ) u_dut (
    .core_clk            (core_clk),
    .rst                 (rst),
    .cal_scale_select    (sel[2]),
    .freq_select_hi      (sel[1]),
    .freq_select_lo      (sel[0]),
    .sample_strobe       (sample_strobe),
    .phase_power_a       (ph_a),
    .phase_power_b       (ph_b),
    .phase_power_c       (ph_c),
    .low_rate_pulse_a    (lr_a),
    .low_rate_pulse_b    (lr_b),
    .cal_pulse_out       (cal),
    .negative_power_flag (flag)
  );

  // One counter per pulse output pin
  epo_pulse_counter u_cnt_a (.core_clk(core_clk), .rst(rst), .pulse(lr_a),
    .rises(a_rises), .last_width(a_width), .last_rise(a_rise));
  epo_pulse_counter u_cnt_b (.core_clk(core_clk), .rst(rst), .pulse(lr_b),
    .rises(b_rises), .last_width(b_width), .last_rise(b_rise));
  epo_pulse_counter u_cnt_c (.core_clk(core_clk), .rst(rst), .pulse(cal),
    .rises(cal_rises), .last_width(cal_width), .last_rise(cal_rise));

  // Clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check_int(input int got, input int exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_int

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check_bit

  task automatic wait_cyc(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask : wait_cyc

  // Select pins are static, so they only change while reset is held
  task automatic start(input logic [2:0] s);
    rst = 1'b1;
    sel = s;
    sample_strobe = 1'b0;
    wait_cyc(8);
    rst = 1'b0;
  endtask : start

  task automatic set_ph(input int pa, input int pb, input int pc);
    ph_a = 16'(pa);
    ph_b = 16'(pb);
    ph_c = 16'(pc);
  endtask : set_ph

  // n strobes, one every s cycles; phases held throughout
  task automatic send(input int n, input int s);
    repeat (n) begin
      sample_strobe = 1'b1;
      wait_cyc(1);
      sample_strobe = 1'b0;
      wait_cyc(s - 1);
    end
  endtask : send

  task automatic run_multiple(input logic [2:0] s, input int mult);
    start(s);
    set_ph(100, 100, 100);
    send(2 * mult, 40);
    wait_cyc(60);
    check_int(cal_rises, 2 * mult);
    check_int(a_rises, 1);
    check_int(b_rises, 1);
    check_int(a_width, LRW);
    check_int(b_width, LRW);
    check_int(cal_width, CALW);
    check_int(int'(b_rise - a_rise), mult * 40);
  endtask : run_multiple

  task automatic run_short_cal(input logic [2:0] s, input int sp, input int exp_w);
    start(s);
    set_ph(100, 100, 100);
    send(10, sp);
    wait_cyc(40);
    check_int(cal_width, exp_w);
  endtask : run_short_cal

  // Below-threshold increments: crossings follow summed power, weight and multiple
  task automatic run_rate(input logic [2:0] s, input int exp_cal, input int exp_lr);
    start(s);
    set_ph(10, 10, 10);
    send(35, 20);
    wait_cyc(40);
    check_int(cal_rises, exp_cal);
    check_int(a_rises, exp_lr);
  endtask : run_rate

  // Low-rate spacing 16 gives a period of 32, under the short bound;
  // the first calibration pulse is full width, so the second fire adds no rise
  task automatic run_fast_low_rate();
    start(3'b011);
    set_ph(100, 100, 100);
    send(32, 2);
    wait_cyc(60);
    check_int(cal_rises, 31);
    check_int(cal_width, 1);
    check_int(a_rises, 2);
    check_int(b_width, 16);
  endtask : run_fast_low_rate

  // Total of 4 sits just under the creep level, 5 just at it
  task automatic run_no_load();
    start(3'b011);
    set_ph(2, 1, 1);
    send(20, 40);
    wait_cyc(40);
    check_int(cal_rises, 0);
    check_int(a_rises, 0);
    set_ph(3, 1, 1);
    send(8, 40);
    wait_cyc(60);
    check_int(cal_rises, 8);
    check_int(a_rises, 1);
  endtask : run_no_load

  task automatic run_flag();
    start(3'b011);
    set_ph(200, 200, -1);
    send(1, 40);
    check_bit(flag, 1'b0);
    set_ph(200, 200, -3);
    send(1, 40);
    check_bit(flag, 1'b1);
    set_ph(-3, 1, 1);
    send(1, 40);
    check_bit(flag, 1'b1);
    set_ph(-100, -100, 300);
    send(1, 40);
    check_bit(flag, 1'b1);
    set_ph(100, 100, 100);
    wait_cyc(20);
    check_bit(flag, 1'b1);
    send(1, 40);
    check_bit(flag, 1'b0);
  endtask : run_flag

  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      run_multiple(3'(i), mults[i]);
    end
    run_short_cal(3'b000, 12, 6);
    run_short_cal(3'b100, 15, 10);
    run_rate(3'b100, 9, 1);
    run_rate(3'b111, 10, 0);
    run_fast_low_rate();
    run_no_load();
    run_flag();
    end_of_test();
  end

  // Watchdog, about twice the expected run
  initial begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb_energy_pulse_output_gen
